/* File: rtl/adc_adv_pkg.sv */
package adc_adv_pkg;

    // ==================================================================
    // Register indices (byte address is four times the index)
    localparam logic [31:0] IDX_CH_STATUS  = 32'h0000_5546;
    localparam logic [31:0] IDX_CH0_RESULT = 32'h0000_5548;
    localparam logic [31:0] IDX_CH1_RESULT = 32'h0000_554a;
    localparam logic [31:0] IDX_CH2_RESULT = 32'h0000_554c;
    localparam logic [31:0] IDX_CH3_RESULT = 32'h0000_554e;
    localparam logic [31:0] IDX_UPPER      = 32'h0000_5558;
    localparam logic [31:0] IDX_LOWER      = 32'h0000_555a;
    localparam logic [31:0] IDX_CHANNEL_COMPLETION_IRQ_ENABLE    = 32'h0000_555c;
    localparam logic [31:0] IDX_MODE       = 32'h0000_555e;
    localparam logic [31:0] IDX_CTRL       = 32'h0000_5560;
    localparam logic [31:0] IDX_IRQ_STAT   = 32'h0000_5562;
    localparam logic [31:0] IDX_IRQ_MASK   = 32'h0000_5564;

    // ==================================================================
    // Field positions
    localparam int unsigned CH_COUNT       = 4;
    localparam int unsigned RESULT_W       = 10;
    localparam int unsigned OVR_LSB        = 8;   // Overrun flags in status word
    localparam int unsigned MODE_BIT       = 8;   // Extended mode select
    localparam int unsigned STATE_LSB      = 4;   // Converter state field
    localparam int unsigned CMP_SEL_LSB    = 12;  // Compare channel select
    localparam int unsigned RANGE_EN_BIT   = 5;   // Range interrupt enable
    localparam int unsigned EVT_W          = 3;
    localparam int unsigned EVT_DONE       = 0;
    localparam int unsigned EVT_RANGE      = 1;
    localparam int unsigned EVT_OVR        = 2;

    // ==================================================================
    // Reset values
    localparam logic [9:0]  RST_LIMIT      = 10'h000;
    localparam logic [3:0]  RST_CHANNEL_COMPLETION_IRQ_ENABLE    = 4'hf;
    localparam logic        RST_MODE       = 1'b0;

    // Converter activity codes
    typedef enum logic [1:0] {
        ST_IDLE       = 2'h0,
        ST_SAMPLING   = 2'h1,
        ST_RESERVED   = 2'h2,
        ST_CONVERTING = 2'h3
    } conv_state_t;

endpackage

/* File: rtl/slot_if.sv */
// Link between the register block and one channel slot
interface slot_if;
    logic       store;
    logic [9:0] data;
    logic       rd;
    logic       ovr_clr;
    logic [9:0] result;
    logic       done;
    logic       ovr;

    modport ctrl (output store, data, rd, ovr_clr, input result, done, ovr);
    modport slot (input store, data, rd, ovr_clr, output result, done, ovr);
endinterface

/* File: rtl/channel_slot.sv */
// One channel: result buffer, completion flag and overrun flag
module channel_slot
    import adc_adv_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    slot_if.slot      port_s
);

    typedef struct packed {
        logic [9:0] result;
        logic       done;
        logic       ovr;
    } slot_state_t;

    slot_state_t cur;
    slot_state_t next_cur;

    // ==================================================================
    // Flag and buffer update
    always_comb begin
        next_cur = cur;
        if (port_s.store) begin
            next_cur.result = port_s.data;
        end
        // A new result wins over a read clearing the flag in the same cycle
        if (port_s.store) begin
            next_cur.done = 1'b1;
        end else if (port_s.rd) begin
            next_cur.done = 1'b0;
        end
        // Overwrite only counts against an unread, uncleared flag
        if (port_s.store && cur.done && !port_s.rd) begin
            next_cur.ovr = 1'b1;
        end else if (port_s.ovr_clr) begin
            next_cur.ovr = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign port_s.result = cur.result;
    assign port_s.done   = cur.done;
    assign port_s.ovr    = cur.ovr;

endmodule

/* File: rtl/adc_adv_regs.sv */
// Behaviour
// - Four 10-bit result buffers, channels 0 to 3, zero after reset.
// - Result buffers are read-only; writes leave them unchanged.
// - Writable 10-bit upper limit, reset zero, for the selected compare channel.
// - Result above upper limit on compare channel can raise range interrupt.
// - Writable 10-bit lower limit, reset zero, same compare channel.
// - Result below lower limit on compare channel can raise range interrupt.
// - Completion interrupt enables reset to one and let completion request.
// - Enable at zero suppresses that channel's completion request.
// - Mode bit: one advanced, zero standard, resets standard.
// - Advanced mode: extended registers and bits are writable.
// - Standard mode: extended registers read-only, writes ignored.
// - Read-only state field: idle, sampling, converting; code two never shown.
// - Read-only 4-bit converter counter view, reset zero.
// - Completion flag set on store, cleared by reading that buffer.
// - Store over a set completion flag sets overrun; cleared writing zero, in advanced mode only.
// - Range results become interrupt cause only while range enable is one.
module adc_adv_regs
    import adc_adv_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Converter core
    input  wire logic        CONV_DONE_I,
    input  wire logic [1:0]  CONV_CH_I,
    input  wire logic [9:0]  CONV_DATA_I,
    input  wire logic [1:0]  CONV_STATE_I,
    input  wire logic [3:0]  CONV_COUNT_I,
    // Status towards the system
    output logic             ADV_MODE_O,
    output logic             CONV_IRQ_O,
    output logic             RANGE_HIT_O,
    output logic             IRQ_O
);

    // ==================================================================
    // State
    typedef struct packed {
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic [9:0]       upper_limit_value;
        logic [9:0]       lower_limit_value;
        logic [3:0]       channel_completion_irq_enable;
        logic             extended_mode_select;
        logic [2:0]       compare_channel_select;
        logic             range_irq_enable;
        conv_state_t      converter_state;
        logic [3:0]       internal_step_counter;
        logic [EVT_W-1:0] irq_stat;
        logic [EVT_W-1:0] irq_mask;
        logic             conv_irq;
        logic             range_hit;
        logic             irq;
    } regs_state_t;

    regs_state_t cur;
    regs_state_t next_cur;

    // ==================================================================
    // Channel slots
    logic [3:0] ch_store;
    logic [3:0] ch_rd;
    logic [3:0] ch_ovr_clr;
    logic [3:0] ch_done;
    logic [3:0] ch_ovr;
    logic [9:0] ch_result [CH_COUNT];

    slot_if sif [CH_COUNT] ();

    genvar g;
    generate
        for (g = 0; g < CH_COUNT; g++) begin : g_slot
            assign sif[g].store   = ch_store[g];
            assign sif[g].data    = CONV_DATA_I;
            assign sif[g].rd      = ch_rd[g];
            assign sif[g].ovr_clr = ch_ovr_clr[g];
            assign ch_result[g]   = sif[g].result;
            assign ch_done[g]     = sif[g].done;
            assign ch_ovr[g]      = sif[g].ovr;

            channel_slot u_slot (
                .clk_i    (CLK_I),
                .arst_n_i (ARST_N_I),
                .port_s   (sif[g])
            );
        end
    endgenerate

    // ==================================================================
    // Bus decode
    logic        access;
    logic        wr_commit;
    logic        rd_commit;
    logic [31:0] word_idx;
    logic        addr_ok;
    logic [31:0] rdata;
    logic        cmp_hit;
    logic        above;
    logic        below;
    logic [EVT_W-1:0] events;

    // Access phase; one wait state so read data comes from a flop
    assign access    = PSEL_I && PENABLE_I;
    assign wr_commit = access && cur.pready && PWRITE_I;
    assign rd_commit = access && cur.pready && !PWRITE_I;
    assign word_idx  = {2'b00, PADDR_I[31:2]};

    // Read mux; unused bits stay zero
    always_comb begin
        rdata   = '0;
        addr_ok = 1'b1;
        unique case (word_idx)
            IDX_CH_STATUS: begin
                rdata[OVR_LSB +: CH_COUNT] = ch_ovr;
                rdata[CH_COUNT-1:0]        = ch_done;
            end
            IDX_CH0_RESULT: rdata[RESULT_W-1:0] = ch_result[0];
            IDX_CH1_RESULT: rdata[RESULT_W-1:0] = ch_result[1];
            IDX_CH2_RESULT: rdata[RESULT_W-1:0] = ch_result[2];
            IDX_CH3_RESULT: rdata[RESULT_W-1:0] = ch_result[3];
            IDX_UPPER:      rdata[RESULT_W-1:0] = cur.upper_limit_value;
            IDX_LOWER:      rdata[RESULT_W-1:0] = cur.lower_limit_value;
            IDX_CHANNEL_COMPLETION_IRQ_ENABLE:    rdata[CH_COUNT-1:0] = cur.channel_completion_irq_enable;
            IDX_MODE: begin
                rdata[MODE_BIT]          = cur.extended_mode_select;
                rdata[STATE_LSB +: 2]    = cur.converter_state;
                rdata[3:0]               = cur.internal_step_counter;
            end
            IDX_CTRL: begin
                rdata[CMP_SEL_LSB +: 3]  = cur.compare_channel_select;
                rdata[RANGE_EN_BIT]      = cur.range_irq_enable;
            end
            IDX_IRQ_STAT:   rdata[EVT_W-1:0] = cur.irq_stat;
            IDX_IRQ_MASK:   rdata[EVT_W-1:0] = cur.irq_mask;
            default:        addr_ok = 1'b0;
        endcase
    end

    // ==================================================================
    // Channel side effects of bus access and conversions
    always_comb begin
        ch_store   = '0;
        ch_rd      = '0;
        ch_ovr_clr = '0;
        if (CONV_DONE_I) begin
            ch_store[CONV_CH_I] = 1'b1;
        end
        // A committed read of a buffer clears that channel's flag
        if (rd_commit) begin
            ch_rd[0] = (word_idx == IDX_CH0_RESULT);
            ch_rd[1] = (word_idx == IDX_CH1_RESULT);
            ch_rd[2] = (word_idx == IDX_CH2_RESULT);
            ch_rd[3] = (word_idx == IDX_CH3_RESULT);
        end
        // Overrun flags clear on a written zero, and only in advanced mode
        if (wr_commit && word_idx == IDX_CH_STATUS && cur.extended_mode_select) begin
            ch_ovr_clr = ~PWDATA_I[OVR_LSB +: CH_COUNT];
        end
    end

    // ==================================================================
    // Range check against the limits
    // Only the selected channel is compared, once per stored result
    assign cmp_hit = CONV_DONE_I && (cur.compare_channel_select == {1'b0, CONV_CH_I});
    assign above   = CONV_DATA_I > cur.upper_limit_value;
    assign below   = CONV_DATA_I < cur.lower_limit_value;

    // Events feeding the sticky status
    always_comb begin
        events            = '0;
        events[EVT_DONE]  = CONV_DONE_I;
        events[EVT_RANGE] = cmp_hit && cur.range_irq_enable && (above || below);
        events[EVT_OVR]   = CONV_DONE_I && ch_done[CONV_CH_I] && !ch_rd[CONV_CH_I];
    end

    // ==================================================================
    // Next state
    always_comb begin
        next_cur = cur;

        // Bus answer: ready pulses for one cycle per access
        next_cur.pready  = access && !cur.pready;
        next_cur.pslverr = access && !cur.pready && !addr_ok;
        if (access && !cur.pready) begin
            next_cur.prdata = PWRITE_I ? 32'h0000_0000 : rdata;
        end

        // Register writes; the mode bit is always writable
        if (wr_commit) begin
            if (word_idx == IDX_MODE) begin
                next_cur.extended_mode_select = PWDATA_I[MODE_BIT];
            end
            // Extended registers take writes only in advanced mode
            if (cur.extended_mode_select) begin
                unique case (word_idx)
                    IDX_UPPER: next_cur.upper_limit_value = PWDATA_I[RESULT_W-1:0];
                    IDX_LOWER: next_cur.lower_limit_value = PWDATA_I[RESULT_W-1:0];
                    IDX_CHANNEL_COMPLETION_IRQ_ENABLE: begin
                        next_cur.channel_completion_irq_enable = PWDATA_I[CH_COUNT-1:0];
                    end
                    IDX_CTRL: begin
                        next_cur.compare_channel_select = PWDATA_I[CMP_SEL_LSB +: 3];
                        next_cur.range_irq_enable       = PWDATA_I[RANGE_EN_BIT];
                    end
                    default: ;
                endcase
            end
            // Interrupt status and mask belong to the system side
            if (word_idx == IDX_IRQ_MASK) begin
                next_cur.irq_mask = PWDATA_I[EVT_W-1:0];
            end
            if (word_idx == IDX_IRQ_STAT) begin
                next_cur.irq_stat = cur.irq_stat & ~PWDATA_I[EVT_W-1:0];
            end
        end

        // New events win over a write-one clear in the same cycle
        next_cur.irq_stat = next_cur.irq_stat | events;

        // Converter views; the reserved code keeps the last legal one
        if (CONV_STATE_I != ST_RESERVED) begin
            next_cur.converter_state = conv_state_t'(CONV_STATE_I);
        end
        next_cur.internal_step_counter = CONV_COUNT_I;

        // Completion request, gated per channel by its enable
        next_cur.conv_irq  = |(ch_done & cur.channel_completion_irq_enable);
        next_cur.range_hit = events[EVT_RANGE];
        next_cur.irq       = |(next_cur.irq_stat & cur.irq_mask);
    end

    // ==================================================================
    // State register
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cur                                <= '0;
            cur.upper_limit_value              <= RST_LIMIT;
            cur.lower_limit_value              <= RST_LIMIT;
            cur.channel_completion_irq_enable  <= RST_CHANNEL_COMPLETION_IRQ_ENABLE;
            cur.extended_mode_select           <= RST_MODE;
            cur.converter_state                <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ==================================================================
    // Outputs straight from the state register
    assign PRDATA_O    = cur.prdata;
    assign PREADY_O    = cur.pready;
    assign PSLVERR_O   = cur.pslverr;
    assign ADV_MODE_O  = cur.extended_mode_select;
    assign CONV_IRQ_O  = cur.conv_irq;
    assign RANGE_HIT_O = cur.range_hit;
    assign IRQ_O       = cur.irq;

endmodule

/* File: tb/adc_adv_regs_checker.sv */
// ==========================================================
// Port-level checks for the advanced result/limit registers
module adc_adv_regs_checker
    import adc_adv_pkg::*;
(
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        ARST_N_I,
    // APB side
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // Converter and status
    input wire logic        CONV_DONE_I,
    input wire logic        ADV_MODE_O,
    input wire logic        CONV_IRQ_O,
    input wire logic        RANGE_HIT_O,
    input wire logic        IRQ_O
);
    logic [29:0] idx;
    logic        rd_ok;

    // Decoded view of the answer in flight
    assign idx   = PADDR_I[31:2];
    assign rd_ok = PREADY_O && !PWRITE_I;

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    // Fixed single wait state keeps the software timing known
    ready_wait_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("ready not one cycle after access");
    ready_pulse_a: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I) ##1 !PREADY_O)
        else $error("ready without access or too long");
    err_zero_a: assert property (rd_ok && PSLVERR_O |-> PRDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    result_rsv_a: assert property (rd_ok && idx >= IDX_CH0_RESULT[29:0] && idx <= IDX_CH3_RESULT[29:0]
        |-> PRDATA_O[31:10] == 0)
        else $error("result upper bits not zero");
    limit_rsv_a: assert property (rd_ok && (idx == IDX_UPPER[29:0] || idx == IDX_LOWER[29:0])
        |-> PRDATA_O[31:10] == 0)
        else $error("limit upper bits not zero");
    state_code_a: assert property (rd_ok && idx == IDX_MODE[29:0]
        |-> PRDATA_O[5:4] != 2'h2 && PRDATA_O[31:9] == 0 && PRDATA_O[7:6] == 0)
        else $error("bad state code or reserved bits");
    mode_view_a: assert property (rd_ok && idx == IDX_MODE[29:0] |-> PRDATA_O[8] == ADV_MODE_O)
        else $error("mode bit read differs from output");
    mode_write_a: assert property ($changed(ADV_MODE_O) |-> $past(PSEL_I && PWRITE_I && PREADY_O))
        else $error("mode changed without a write");
    range_cause_a: assert property (RANGE_HIT_O |-> $past(CONV_DONE_I) || $past(CONV_DONE_I, 2))
        else $error("range hit without a conversion");

    // Main scenarios reached
    cover property (RANGE_HIT_O);
    cover property (rd_ok && PSLVERR_O);
    cover property ($rose(IRQ_O));
    cover property ($rose(CONV_IRQ_O));
endmodule

/* File: tb/adc_adv_regs_bench.sv */
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end

// ==========================================================
// Self-checking bench for the advanced result/limit registers
module adc_adv_regs_bench
    import adc_adv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        CLK_I = 0, ARST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
    logic [31:0] PADDR_I = 0, PWDATA_I = 0;
    logic        CONV_DONE_I = 0;
    logic [1:0]  CONV_CH_I = 0, CONV_STATE_I = 0;
    logic [9:0]  CONV_DATA_I = 0;
    logic [3:0]  CONV_COUNT_I = 0;
    wire  [31:0] PRDATA_O;
    wire         PREADY_O, PSLVERR_O, ADV_MODE_O, CONV_IRQ_O, RANGE_HIT_O, IRQ_O;
    int          errors = 0, checks = 0;
    logic [32:0] q[$];
    logic [32:0] note;
    logic [15:0] lf = 16'h6d71;
    logic        hit_seen = 0;
    logic [9:0]  d[4];
    // Channel, sample, expected hit; sits on both sides of each limit
    // Bits 12:11 channel, 10:1 sample, 0 hit; limits 0x100..0x200 on channel 1
    logic [12:0] tab[5] = '{13'h0c03, 13'h0c00, 13'h09ff, 13'h0a00, 13'h17fe};

    adc_adv_regs dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
        .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
        .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CONV_DONE_I(CONV_DONE_I), .CONV_CH_I(CONV_CH_I),
        .CONV_DATA_I(CONV_DATA_I), .CONV_STATE_I(CONV_STATE_I), .CONV_COUNT_I(CONV_COUNT_I),
        .ADV_MODE_O(ADV_MODE_O), .CONV_IRQ_O(CONV_IRQ_O), .RANGE_HIT_O(RANGE_HIT_O), .IRQ_O(IRQ_O));

    initial begin
        forever #20 CLK_I = ~CLK_I;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // ======================================================
    // Drivers: one APB transfer, one converter store
    task automatic apb(input logic w, input logic [31:0] ix, input logic [31:0] wd, input logic [32:0] e);
        int n;
        @(posedge CLK_I);
        PSEL_I <= 1'b1;
        PENABLE_I <= 1'b0;
        PWRITE_I <= w;
        PADDR_I <= {ix[29:0], 2'b00};
        PWDATA_I <= wd;
        if (!w) q.push_back(e);
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        // No latency assumed: ready is looked at mid-cycle, where it has settled
        do begin
            @(negedge CLK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            stop_test;
        end
        // The rising edge that samples ready high commits the transfer
        @(posedge CLK_I);
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] ix, input logic [31:0] wd);
        apb(1'b1, ix, wd, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [31:0] ix, input logic [31:0] e);
        apb(1'b0, ix, 32'h0000_0000, {1'b0, e});
    endtask

    task automatic conv(input logic [1:0] ch, input logic [9:0] v);
        @(posedge CLK_I);
        CONV_DONE_I <= 1'b1;
        CONV_CH_I <= ch;
        CONV_DATA_I <= v;
        @(posedge CLK_I);
        CONV_DONE_I <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    // Oldest read note against each read answer, looked at mid-cycle
    always @(negedge CLK_I) begin
        if (PREADY_O === 1'b1 && PWRITE_I === 1'b0 && q.size() > 0) begin
            note = q.pop_front();
            `CHK("read data", note, {PSLVERR_O, PRDATA_O})
        end
    end

    // Range pulse is short, so it is latched here
    always @(posedge CLK_I) begin
        if (RANGE_HIT_O === 1'b1) hit_seen <= 1'b1;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        stop_test;
    end

    // ======================================================
    // Scenarios
    initial begin
        repeat (8) @(posedge CLK_I);
        ARST_N_I <= 1'b1;
        for (int i = 0; i < 4; i++) rd(IDX_CH0_RESULT + 32'(2 * i), 32'h0000_0000);
        rd(IDX_UPPER, 32'h0000_0000);
        rd(IDX_LOWER, 32'h0000_0000);
        rd(IDX_CHANNEL_COMPLETION_IRQ_ENABLE, 32'h0000_000f);
        rd(IDX_MODE, 32'h0000_0000);
        rd(IDX_CH_STATUS, 32'h0000_0000);
        apb(1'b0, 32'h0000_5566, 32'h0000_0000, 33'h1_0000_0000);
        tend("reset");
        // Standard mode leaves extended registers untouched
        wr(IDX_UPPER, 32'h0000_03ff);
        wr(IDX_CHANNEL_COMPLETION_IRQ_ENABLE, 32'h0000_0000);
        rd(IDX_UPPER, 32'h0000_0000);
        rd(IDX_CHANNEL_COMPLETION_IRQ_ENABLE, 32'h0000_000f);
        tend("standard");
        CONV_STATE_I <= 2'h3;
        CONV_COUNT_I <= 4'ha;
        wr(IDX_MODE, 32'hffff_ffff);
        rd(IDX_MODE, 32'h0000_013a);
        CONV_STATE_I <= 2'h2;
        rd(IDX_MODE, 32'h0000_013a);
        CONV_STATE_I <= 2'h1;
        CONV_COUNT_I <= 4'hf;
        rd(IDX_MODE, 32'h0000_011f);
        `CHK("mode out", 1'b1, ADV_MODE_O)
        wr(IDX_CH0_RESULT, 32'h0000_03ff);
        rd(IDX_CH0_RESULT, 32'h0000_0000);
        lf = lfsr(lf);
        wr(IDX_UPPER, {16'h0000, lf});
        rd(IDX_UPPER, {22'h0, lf[9:0]});
        tend("mode");
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            d[i] = lf[9:0];
            conv(2'(i), d[i]);
        end
        rd(IDX_CH_STATUS, 32'h0000_000f);
        tick(1);
        `CHK("completion irq", 1'b1, CONV_IRQ_O)
        for (int i = 0; i < 4; i++) rd(IDX_CH0_RESULT + 32'(2 * i), {22'h0, d[i]});
        rd(IDX_CH_STATUS, 32'h0000_0000);
        tick(2);
        `CHK("completion irq", 1'b0, CONV_IRQ_O)
        tend("store");
        conv(2'h1, 10'h005);
        conv(2'h1, 10'h006);
        wr(IDX_CH_STATUS, 32'h0000_0200);
        rd(IDX_CH_STATUS, 32'h0000_0202);
        wr(IDX_CH_STATUS, 32'h0000_0000);
        rd(IDX_CH_STATUS, 32'h0000_0002);
        rd(IDX_CH1_RESULT, 32'h0000_0006);
        tend("overrun");
        wr(IDX_CHANNEL_COMPLETION_IRQ_ENABLE, 32'h0000_000b);
        conv(2'h2, 10'h007);
        tick(2);
        `CHK("masked irq", 1'b0, CONV_IRQ_O)
        wr(IDX_CHANNEL_COMPLETION_IRQ_ENABLE, 32'h0000_000f);
        tick(2);
        `CHK("unmasked irq", 1'b1, CONV_IRQ_O)
        rd(IDX_CH2_RESULT, 32'h0000_0007);
        tend("mask");
        wr(IDX_UPPER, 32'h0000_0200);
        wr(IDX_LOWER, 32'h0000_0100);
        wr(IDX_CTRL, 32'h0000_1020);
        for (int i = 0; i < 5; i++) begin
            tick(1);
            hit_seen = 1'b0;
            conv(tab[i][12:11], tab[i][10:1]);
            tick(3);
            `CHK("range hit", tab[i][0], hit_seen)
        end
        `CHK("irq masked", 1'b0, IRQ_O)
        wr(IDX_IRQ_MASK, 32'h0000_0002);
        tick(2);
        `CHK("irq raised", 1'b1, IRQ_O)
        wr(IDX_IRQ_STAT, 32'h0000_0002);
        tick(2);
        `CHK("irq cleared", 1'b0, IRQ_O)
        wr(IDX_CTRL, 32'h0000_1000);
        conv(2'h1, 10'h3ff);
        tick(3);
        `CHK("range off", 1'b0, IRQ_O)
        tend("range");
        wr(IDX_MODE, 32'h0000_0000);
        wr(IDX_LOWER, 32'h0000_0003);
        rd(IDX_LOWER, 32'h0000_0100);
        `CHK("mode out", 1'b0, ADV_MODE_O)
        tend("back to standard");
        tick(3);
        stop_test;
    end
endmodule

bind adc_adv_regs adc_adv_regs_checker chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CONV_DONE_I(CONV_DONE_I), .ADV_MODE_O(ADV_MODE_O),
    .CONV_IRQ_O(CONV_IRQ_O), .RANGE_HIT_O(RANGE_HIT_O), .IRQ_O(IRQ_O));
